// *** logic/esd_top.sv ***
/*
 Enclosure status display: drives two seven-segment digits, the diagnostic
 point lamp and the needs-attention indicator of an enclosure service unit.
 Assumes status inputs come from the unit controller on CLK_IN, so none are
 synchronised; reset is synchronous and active high.
*/
// Notes on behaviour
// - From power-on until boot firmware runs, both digits show eight-eight.
// - Once boot code starts, each digit shows a dash.
// - When application code starts, show aa for the first unit or bb for the second.
// - In normal operation the digits show the enclosure identifier.
// - The point lamp is lit whenever the digits show diagnostics instead of the identifier.
// - The point lamp is dark whenever the identifier is shown.
// - Start-up shows diagnostic codes, then switches to the current identifier.
// - State codes are L or H then one hex digit, shown mainly while non-operational.
// - A configuration-caused suspend keeps the needs-attention indicator off.
// - A hardware-fault suspend turns the needs-attention indicator on.
// - L-class suspend codes are L0, L2, L3 and L9 for their documented causes.
// - H-class suspend codes are H0 to H6 and H8 for their documented causes.
// - While operational, H7 shows when the link rate or the rate switch differs from the switch setting latched after reset.
// - While held in reset by the peer unit, both digits show eight-eight.
`timescale 1ns/1ps
module esd_top (
	// Clock and reset
	input  wire logic       CLK_IN,
	input  wire logic       SRST_IN,
	// Firmware progress
	input  wire logic       BOOT_STARTED_IN,
	input  wire logic       APP_STARTED_IN,
	input  wire logic       DIAG_DONE_IN,
	input  wire logic [3:0] DIAG_CODE_IN,
	input  wire logic       UNIT_SEL_B_IN,
	// Enclosure state
	input  wire logic [7:0] ENCL_ID_IN,
	input  wire logic       PEER_HOLD_IN,
	input  wire logic       SUSPEND_IN,
	input  wire logic [1:0] FAULT_CLASS_IN,
	input  wire logic [3:0] FAULT_CODE_IN,
	input  wire logic       FAULT_IS_HW_IN,
	input  wire logic [1:0] LINK_RATE_IN,
	input  wire logic [1:0] RATE_SWITCH_IN,
	// Indicators
	output logic      [6:0] SEG_HI_OUT,
	output logic      [6:0] SEG_LO_OUT,
	output logic            DP_OUT,
	output logic            ATTN_OUT
);

	////////////////////////////////////////////////////////////////////////
	// Phase sequencing

	esd_pkg::esd_phase_t phase_r;
	esd_pkg::esd_phase_t phase_nxt;
	logic [1:0]          rate_lat_r;
	logic [1:0]          rate_lat_nxt;
	logic                rate_seen_r;
	logic                rate_seen_nxt;

	always_comb
	begin
		phase_nxt     = phase_r;
		rate_lat_nxt  = rate_lat_r;
		rate_seen_nxt = rate_seen_r;
		unique case (phase_r)
			esd_pkg::PH_LAMP:
				if (BOOT_STARTED_IN)
					phase_nxt = esd_pkg::PH_BOOT;
			esd_pkg::PH_BOOT:
				if (APP_STARTED_IN)
					phase_nxt = esd_pkg::PH_APP;
			esd_pkg::PH_APP:
				phase_nxt = esd_pkg::PH_DIAG;
			esd_pkg::PH_DIAG:
				if (DIAG_DONE_IN)
					phase_nxt = esd_pkg::PH_RUN;
			esd_pkg::PH_RUN:
				phase_nxt = esd_pkg::PH_RUN;
			esd_pkg::PH_HELD:
				if (!PEER_HOLD_IN)
					phase_nxt = esd_pkg::PH_LAMP;
		endcase
		// Peer hold overrides any phase
		if (PEER_HOLD_IN)
			phase_nxt = esd_pkg::PH_HELD;
		// Rate switch is captured once; a later change waits for the next SRST_IN reset
		if (!rate_seen_r)
		begin
			rate_lat_nxt  = RATE_SWITCH_IN;
			rate_seen_nxt = 1'b1;
		end
	end

	always_ff @(posedge CLK_IN)
	begin
		if (SRST_IN)
		begin
			phase_r     <= esd_pkg::PH_LAMP;
			rate_lat_r  <= 2'h0;
			rate_seen_r <= 1'b0;
		end
		else
		begin
			phase_r     <= phase_nxt;
			rate_lat_r  <= rate_lat_nxt;
			rate_seen_r <= rate_seen_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Glyph selection

	logic [4:0] gl_hi;
	logic [4:0] gl_lo;
	logic       dp_nxt;
	logic       attn_nxt;
	logic       rate_diff;
	logic [1:0] link_rate_d;

	// Compare against the rate in use, switch setting only latched at start
	assign link_rate_d = LINK_RATE_IN;
	assign rate_diff   = rate_seen_r && (RATE_SWITCH_IN != rate_lat_r || link_rate_d != rate_lat_r);

	always_comb
	begin
		gl_hi    = esd_pkg::GL_BLANK;
		gl_lo    = esd_pkg::GL_BLANK;
		dp_nxt   = 1'b1;
		attn_nxt = 1'b0;
		unique case (phase_r)
			esd_pkg::PH_LAMP, esd_pkg::PH_HELD:
			begin
				gl_hi = esd_pkg::GL_EIGHT;
				gl_lo = esd_pkg::GL_EIGHT;
			end
			esd_pkg::PH_BOOT:
			begin
				gl_hi = esd_pkg::GL_DASH;
				gl_lo = esd_pkg::GL_DASH;
			end
			esd_pkg::PH_APP:
			begin
				gl_hi = UNIT_SEL_B_IN ? esd_pkg::GL_B_LC : esd_pkg::GL_A_LC;
				gl_lo = gl_hi;
			end
			esd_pkg::PH_DIAG:
			begin
				gl_hi = {1'b0, DIAG_CODE_IN};
				gl_lo = esd_pkg::GL_BLANK;
			end
			esd_pkg::PH_RUN:
			begin
				if (SUSPEND_IN && FAULT_CLASS_IN != esd_pkg::CLASS_NONE)
				begin
					gl_hi    = (FAULT_CLASS_IN == esd_pkg::CLASS_L) ? esd_pkg::GL_L
					                                                 : esd_pkg::GL_H;
					gl_lo    = {1'b0, FAULT_CODE_IN};
					attn_nxt = FAULT_IS_HW_IN;
				end
				else if (rate_diff)
				begin
					gl_hi    = esd_pkg::GL_H;
					gl_lo    = {1'b0, esd_pkg::H_RATE_DIFF};
					attn_nxt = 1'b1;
				end
				else
				begin
					gl_hi  = {1'b0, ENCL_ID_IN[7:4]};
					gl_lo  = {1'b0, ENCL_ID_IN[3:0]};
					dp_nxt = 1'b0;
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Segment decode and output registers

	logic [6:0] seg_hi_nxt;
	logic [6:0] seg_lo_nxt;

	esd_glyph u_glyph_hi (
		.glyph_in (gl_hi),
		.seg_out  (seg_hi_nxt)
	);

	esd_glyph u_glyph_lo (
		.glyph_in (gl_lo),
		.seg_out  (seg_lo_nxt)
	);

	always_ff @(posedge CLK_IN)
	begin
		if (SRST_IN)
		begin
			SEG_HI_OUT <= esd_pkg::SEG_ALL;
			SEG_LO_OUT <= esd_pkg::SEG_ALL;
			DP_OUT     <= 1'b1;
			ATTN_OUT   <= 1'b0;
		end
		else
		begin
			SEG_HI_OUT <= seg_hi_nxt;
			SEG_LO_OUT <= seg_lo_nxt;
			DP_OUT     <= dp_nxt;
			ATTN_OUT   <= attn_nxt;
		end
	end

endmodule

// *** logic/esd_pkg.sv ***
/*
 Enclosure status display package: phases, code classes, glyph indices and segment patterns.
 Assumes segment order {g,f,e,d,c,b,a}, active high, driven by the top module.
*/
package esd_pkg;

	// Display phases
	typedef enum logic [5:0] {
		PH_LAMP  = 6'h01,
		PH_BOOT  = 6'h02,
		PH_APP   = 6'h04,
		PH_DIAG  = 6'h08,
		PH_RUN   = 6'h10,
		PH_HELD  = 6'h20
	} esd_phase_t;

	// Fault class of a suspend code
	localparam logic [1:0] CLASS_NONE = 2'h0;
	localparam logic [1:0] CLASS_L    = 2'h1;
	localparam logic [1:0] CLASS_H    = 2'h2;

	// Glyph indices: 0..F hex digits, then letters and marks
	localparam logic [4:0] GL_L     = 5'h10;
	localparam logic [4:0] GL_H     = 5'h11;
	localparam logic [4:0] GL_A_LC  = 5'h12;
	localparam logic [4:0] GL_B_LC  = 5'h13;
	localparam logic [4:0] GL_DASH  = 5'h14;
	localparam logic [4:0] GL_EIGHT = 5'h08;
	localparam logic [4:0] GL_BLANK = 5'h15;

	// Fault codes in the suspend state, and H7 shown while operational
	localparam logic [3:0] L_TYPE_MISMATCH = 4'h0;
	localparam logic [3:0] L_MEM_ERR       = 4'h2;
	localparam logic [3:0] L_HW_ERR        = 4'h3;
	localparam logic [3:0] L_OVER_TEMP     = 4'h9;
	localparam logic [3:0] H_IF_FAIL       = 4'h0;
	localparam logic [3:0] H_XCVR_SPEED    = 4'h1;
	localparam logic [3:0] H_BAD_CONFIG    = 4'h2;
	localparam logic [3:0] H_REBOOT_LIMIT  = 4'h3;
	localparam logic [3:0] H_PEER_LOST     = 4'h4;
	localparam logic [3:0] H_HARNESS       = 4'h5;
	localparam logic [3:0] H_FW_FAIL       = 4'h6;
	localparam logic [3:0] H_RATE_DIFF     = 4'h7;
	localparam logic [3:0] H_XCVR_SLOT     = 4'h8;

	// Segment patterns {g,f,e,d,c,b,a}
	localparam logic [6:0] SEG_ALL   = 7'h7F;
	localparam logic [6:0] SEG_DASH  = 7'h40;
	localparam logic [6:0] SEG_OFF   = 7'h00;

endpackage

// *** logic/esd_glyph.sv ***
/*
 Glyph to seven-segment decoder for one digit.
 Assumes glyph indices from esd_pkg; purely combinational.
*/
`timescale 1ns/1ps
module esd_glyph (
	// Glyph in
	input  wire logic [4:0] glyph_in,
	// Segments out
	output logic      [6:0] seg_out
);

	always_comb
	begin
		unique case (glyph_in)
			5'h00: seg_out = 7'h3F;
			5'h01: seg_out = 7'h06;
			5'h02: seg_out = 7'h5B;
			5'h03: seg_out = 7'h4F;
			5'h04: seg_out = 7'h66;
			5'h05: seg_out = 7'h6D;
			5'h06: seg_out = 7'h7D;
			5'h07: seg_out = 7'h07;
			5'h08: seg_out = esd_pkg::SEG_ALL;
			5'h09: seg_out = 7'h6F;
			5'h0A: seg_out = 7'h77;
			5'h0B: seg_out = 7'h7C;
			5'h0C: seg_out = 7'h39;
			5'h0D: seg_out = 7'h5E;
			5'h0E: seg_out = 7'h79;
			5'h0F: seg_out = 7'h71;
			esd_pkg::GL_L:    seg_out = 7'h38;
			esd_pkg::GL_H:    seg_out = 7'h76;
			esd_pkg::GL_A_LC: seg_out = 7'h5F;
			esd_pkg::GL_B_LC: seg_out = 7'h7C;
			esd_pkg::GL_DASH: seg_out = esd_pkg::SEG_DASH;
			default:          seg_out = esd_pkg::SEG_OFF;
		endcase
	end

endmodule

// *** sim/esd_disp_model.sv ***
/*
 Display model: the two digits and point lamp as a viewer sees them.
 Assumes active-high segment drive straight from esd_top.
*/
`timescale 1ns/1ps
module esd_disp_model (
	// Drive in
	input  wire logic [6:0] hi_in,
	input  wire logic [6:0] lo_in,
	input  wire logic       dp_in,
	// Seen out
	output logic      [14:0] seen_out
);
	// LEDs follow at once; no persistence modelled
	assign seen_out = {dp_in, hi_in, lo_in};
endmodule

// *** sim/esd_top_asserts.sv ***
/*
 Port checker for esd_top.
 Assumes it is bound to esd_top and sees only its ports.
*/
`timescale 1ns/1ps
module esd_top_chk (
	// Clock and reset
	input wire logic       CLK_IN,
	input wire logic       SRST_IN,
	// Status
	input wire logic       UNIT_SEL_B_IN,
	input wire logic       PEER_HOLD_IN,
	input wire logic       SUSPEND_IN,
	input wire logic [1:0] FAULT_CLASS_IN,
	input wire logic       FAULT_IS_HW_IN,
	// Indicators
	input wire logic [6:0] SEG_HI_OUT,
	input wire logic [6:0] SEG_LO_OUT,
	input wire logic       DP_OUT,
	input wire logic       ATTN_OUT
);
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (SRST_IN);
	a_reset_lamp: assert property ($fell(SRST_IN) |-> SEG_HI_OUT == 7'h7F
		&& SEG_LO_OUT == 7'h7F && DP_OUT && !ATTN_OUT) else $error("no lamp test");
	a_hold_eights: assert property (PEER_HOLD_IN [*3] |-> SEG_HI_OUT == 7'h7F
		&& SEG_LO_OUT == 7'h7F && DP_OUT) else $error("hold not 88");
	a_attn_point: assert property (ATTN_OUT |-> DP_OUT) else $error("attn w/o dp");
	a_cfg_attn_off: assert property ((SUSPEND_IN && FAULT_CLASS_IN != 2'h0
		&& !FAULT_IS_HW_IN) [*3] |-> !ATTN_OUT) else $error("cfg attn on");
	a_lcode_left: assert property ((SUSPEND_IN && FAULT_CLASS_IN == 2'h1
		&& ATTN_OUT) [*3] |-> SEG_HI_OUT == 7'h38) else $error("no L");
	a_hcode_left: assert property ((SUSPEND_IN && FAULT_CLASS_IN == 2'h2
		&& ATTN_OUT) [*3] |-> SEG_HI_OUT == 7'h76) else $error("no H");
	a_boot_dash: assert property (SEG_LO_OUT == 7'h40 |-> SEG_HI_OUT == 7'h40
		&& DP_OUT) else $error("bad dash");
	a_unit_pair: assert property (SEG_LO_OUT == 7'h5F |-> SEG_HI_OUT == 7'h5F
		&& !$past(UNIT_SEL_B_IN)) else $error("bad aa");
	c_attn: cover property (ATTN_OUT);
	c_dash: cover property (SEG_LO_OUT == 7'h40);
	c_bb: cover property (SEG_HI_OUT == 7'h7C && SEG_LO_OUT == 7'h7C);
endmodule
bind esd_top esd_top_chk chk_u (.*);

// *** sim/test_esd_top.sv ***
/*
 Testbench for esd_top: start-up, codes, hold and rate cases.
 Assumes esd_disp_model and the bound checker.
*/
`timescale 1ns/1ps
module test_esd_top;
	logic        clk, srst, boot, app, done, unit_b, hold, susp, hw;
	logic [3:0]  dcode, fcode;
	logic [7:0]  id;
	logic [1:0]  fclass, lrate, rsw;
	logic [6:0]  hi, lo;
	logic        dp, attn;
	logic [14:0] seen;
	int          miscompares = 0;
	int          samples_checked = 0;
	int          cyc = 0;
	logic [6:0]  hx [16] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h07,
		7'h7F, 7'h6F, 7'h77, 7'h7C, 7'h39, 7'h5E, 7'h79, 7'h71};
	esd_top dut_u (.CLK_IN(clk), .SRST_IN(srst), .BOOT_STARTED_IN(boot),
		.APP_STARTED_IN(app), .DIAG_DONE_IN(done), .DIAG_CODE_IN(dcode),
		.UNIT_SEL_B_IN(unit_b), .ENCL_ID_IN(id), .PEER_HOLD_IN(hold), .SUSPEND_IN(susp),
		.FAULT_CLASS_IN(fclass), .FAULT_CODE_IN(fcode), .FAULT_IS_HW_IN(hw),
		.LINK_RATE_IN(lrate), .RATE_SWITCH_IN(rsw), .SEG_HI_OUT(hi), .SEG_LO_OUT(lo),
		.DP_OUT(dp), .ATTN_OUT(attn));
	esd_disp_model disp_u (.hi_in(hi), .lo_in(lo), .dp_in(dp), .seen_out(seen));
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Polls a few cycles: phase changes add latency
	task automatic expect_out(input logic [6:0] e_hi, e_lo, input logic e_dp, e_at);
		int k;
		logic ok;
		k = 0;
		do
		begin
			@(negedge clk);
			k++;
			ok = seen === {e_dp, e_hi, e_lo} && attn === e_at;
		end
		while (!ok && k < 8);
		samples_checked++;
		if (!ok)
		begin
			miscompares++;
			$display("[ERR] %0t shown %h attn %b", $time, seen, attn);
		end
	endtask
	task automatic conclude();
		if (miscompares == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic t_start(input logic b);
		step(1);
		{boot, app, done, srst} = 4'h1;
		unit_b = b;
		step(4);
		srst = 1'b0;
		expect_out(7'h7F, 7'h7F, 1'b1, 1'b0);
		step(1);
		boot = 1'b1;
		expect_out(7'h40, 7'h40, 1'b1, 1'b0);
		step(1);
		app = 1'b1;
		expect_out(b ? 7'h7C : 7'h5F, b ? 7'h7C : 7'h5F, 1'b1, 1'b0);
		expect_out(hx[5], 7'h00, 1'b1, 1'b0);
		step(1);
		done = 1'b1;
		expect_out(hx[3], hx[12], 1'b0, 1'b0);
	endtask
	task automatic t_codes();
		logic [4:0] c [12] = '{5'h00, 5'h02, 5'h03, 5'h09, 5'h10, 5'h11, 5'h12, 5'h13,
			5'h14, 5'h15, 5'h16, 5'h18};
		foreach (c[i])
		begin
			step(1);
			{susp, fclass, fcode, hw} = {1'b1, c[i][4] ? 2'h2 : 2'h1, c[i][3:0], i[0]};
			expect_out(c[i][4] ? 7'h76 : 7'h38, hx[c[i][3:0]], 1'b1, hw);
		end
		step(1);
		susp = 1'b0;
		expect_out(hx[3], hx[12], 1'b0, 1'b0);
	endtask
	task automatic t_hold();
		step(1);
		hold = 1'b1;
		expect_out(7'h7F, 7'h7F, 1'b1, 1'b0);
		step(1);
		hold = 1'b0;
		expect_out(7'h40, 7'h40, 1'b1, 1'b0);
		expect_out(hx[3], hx[12], 1'b0, 1'b0);
	endtask
	task automatic t_rate();
		step(1);
		lrate = 2'h1;
		expect_out(7'h76, hx[7], 1'b1, 1'b1);
		step(1);
		rsw = 2'h1;
		expect_out(7'h76, hx[7], 1'b1, 1'b1);
		step(1);
		{susp, fclass, fcode, hw} = {1'b1, 2'h1, 4'h3, 1'b0};
		expect_out(7'h38, hx[3], 1'b1, 1'b0);
		step(1);
		susp = 1'b0;
	endtask
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			miscompares++;
			conclude();
		end
	end
	initial
	begin
		{srst, boot, app, done, unit_b, hold, susp, hw} = 8'h80;
		{dcode, fcode, fclass, lrate, rsw} = 14'h1400;
		id = 8'h3C;
		t_start(1'b0);
		t_codes();
		t_hold();
		t_rate();
		t_start(1'b1);
		conclude();
	end
endmodule
